// >>> verilog/alu_core.sv
// Overview of operation
// - table read: low byte to memory, high latched
// - xor into accumulator, only zero flag
// - xor result written back to memory byte
// - xor immediate into accumulator, zero flag
// - extended forms use full address, no bank
// - add with carry into accumulator, arithmetic flags
// - add with carry into memory, arithmetic flags
// - add into accumulator, arithmetic flags
// - add into memory, arithmetic flags
// - and into accumulator, only zero flag
// - and into memory, only zero flag
// - byte clear writes zero, flags kept
// - bit clear touches one bit, flags kept
`timescale 1ns/100ps
`include "alu_defs.svh"
module alu_core import alu_pkg::*; (
	// clock and reset
	input  wire logic                   CLOCK_I,
	input  wire logic                   RST_N_I,
	// instruction decoder
	input  wire logic                   CMD_VALID_I,
	input  wire cmd_t                   CMD_I,
	output logic                        BUSY_O,
	output logic                        DONE_O,
	// program memory
	output logic                        PM_RD_O,
	output logic [`PM_ADDR_W-1:0]       PM_ADDR_O,
	input  wire logic [15:0]            PM_DATA_I,
	// register bus
	input  wire bus_req_t               BUS_I,
	output logic [7:0]                  BUS_RDATA_O,
	// core state
	output logic [7:0]                  ACC_O,
	output logic [`STATUS_W-1:0]        STATUS_O
);
	state_t                 state_q;
	logic [7:0]             acc_q;
	logic [`STATUS_W-1:0]   status_q;
	logic [`STATUS_W-1:0]   status_d;
	logic [7:0]             tpl_q;
	logic [7:0]             tph_q;
	logic [7:0]             thl_q;
	logic [1:0]             bank_q;
	logic [`DM_ADDR_W-1:0]  dest_q;
	logic                   done_q;
	logic                   busy_q;
	logic                   prd_q;
	logic [`PM_ADDR_W-1:0]  paddr_q;
	logic [7:0]             rdata_q;
	logic                   take;
	logic                   is_ext;
	logic [`DM_ADDR_W-1:0]  m_addr;
	logic [7:0]             mem_m;
	logic [7:0]             mem_bus;
	logic [7:0]             res;
	logic                   wr_acc;
	logic                   wr_mem;
	logic                   upd_z;
	logic                   upd_arith;
	logic                   cin;
	logic [8:0]             sum9;
	logic [4:0]             low5;
	logic                   ov;
	logic                   mem_we;
	logic [`DM_ADDR_W-1:0]  mem_wa;
	logic [7:0]             mem_wd;
	logic [7:0]             pm_hi;
	logic                   bus_dm;
	logic                   bus_acc_wr;
	logic                   bus_st_wr;
	assign take       = CMD_VALID_I && state_q == ST_IDLE;
	assign bus_dm     = BUS_I.addr[`DM_WIN_BIT];
	assign bus_acc_wr = BUS_I.wr && BUS_I.addr == `REG_ACC;
	assign bus_st_wr  = BUS_I.wr && BUS_I.addr == `REG_STATUS;
	assign pm_hi      = PM_DATA_I[15:8];
	// extended forms reach any section directly
	assign is_ext = CMD_I.op inside {OP_ADC_ACC, OP_ADC_MEM, OP_ADD_ACC, OP_ADD_MEM,
		OP_AND_ACC, OP_AND_MEM, OP_CLR_MEM, OP_CLR_BIT};
	assign m_addr = is_ext ? CMD_I.addr : {bank_q, CMD_I.addr[7:0]};
	data_ram data_ram_inst (
		.clk_i     (CLOCK_I),
		.rst_n_i   (RST_N_I),
		.wr_i      (mem_wr_t'{we: mem_we, addr: mem_wa, data: mem_wd}),
		.ra_addr_i (m_addr),
		.ra_data_o (mem_m),
		.rb_addr_i (BUS_I.addr[`DM_ADDR_W-1:0]),
		.rb_data_o (mem_bus)
	);
	// shared adder, carry only for the carry forms
	assign cin  = (CMD_I.op == OP_ADC_ACC || CMD_I.op == OP_ADC_MEM) && status_q[`FLG_C];
	assign sum9 = {1'b0, acc_q} + {1'b0, mem_m} + {8'h00, cin};
	assign low5 = {1'b0, acc_q[3:0]} + {1'b0, mem_m[3:0]} + {4'h0, cin};
	assign ov   = (acc_q[7] == mem_m[7]) && (sum9[7] != acc_q[7]);
	always_comb begin
		res       = 8'h00;
		wr_acc    = 1'b0;
		wr_mem    = 1'b0;
		upd_z     = 1'b0;
		upd_arith = 1'b0;
		case (CMD_I.op)
			OP_XOR_ACC: begin
				res    = acc_q ^ mem_m;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			OP_XOR_MEM: begin
				res    = acc_q ^ mem_m;
				wr_mem = 1'b1;
				upd_z  = 1'b1;
			end
			OP_XOR_IMM: begin
				res    = acc_q ^ CMD_I.imm;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			OP_ADC_ACC, OP_ADD_ACC: begin
				res       = sum9[7:0];
				wr_acc    = 1'b1;
				upd_arith = 1'b1;
			end
			OP_ADC_MEM, OP_ADD_MEM: begin
				res       = sum9[7:0];
				wr_mem    = 1'b1;
				upd_arith = 1'b1;
			end
			OP_AND_ACC: begin
				res    = acc_q & mem_m;
				wr_acc = 1'b1;
				upd_z  = 1'b1;
			end
			OP_AND_MEM: begin
				res    = acc_q & mem_m;
				wr_mem = 1'b1;
				upd_z  = 1'b1;
			end
			OP_CLR_MEM: begin
				res    = `CLR_VALUE;
				wr_mem = 1'b1;
			end
			OP_CLR_BIT: begin
				res    = mem_m & ~(8'h01 << CMD_I.bit_sel);
				wr_mem = 1'b1;
			end
			default: res = 8'h00;
		endcase
	end
	// memory write: table load, then the op, then the bus
	// a bus write to memory colliding with a core write is dropped
	always_comb begin
		mem_we = 1'b0;
		mem_wa = m_addr;
		mem_wd = res;
		if (state_q == ST_LOAD) begin
			mem_we = 1'b1;
			mem_wa = dest_q;
			mem_wd = PM_DATA_I[7:0];
		end else if (take && wr_mem) begin
			mem_we = 1'b1;
		end else if (BUS_I.wr && bus_dm) begin
			mem_we = 1'b1;
			mem_wa = BUS_I.addr[`DM_ADDR_W-1:0];
			mem_wd = BUS_I.wdata;
		end
	end
	// flags: bus write first, core update on top
	always_comb begin
		status_d = status_q;
		if (bus_st_wr) begin
			status_d = BUS_I.wdata[`STATUS_W-1:0];
		end
		if (take && (upd_z || upd_arith)) begin
			status_d[`FLG_Z] = (res == 8'h00);
		end
		if (take && upd_arith) begin
			status_d[`FLG_C]  = sum9[8];
			status_d[`FLG_AC] = low5[4];
			status_d[`FLG_OV] = ov;
			status_d[`FLG_SC] = ov ^ sum9[7];
		end
	end
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			status_q <= `STATUS_RST;
		end else begin
			status_q <= status_d;
		end
	end
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			acc_q <= `ACC_RST;
		end else if (take && wr_acc) begin
			acc_q <= res;
		end else if (bus_acc_wr) begin
			acc_q <= BUS_I.wdata;
		end
	end
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			tpl_q  <= `TP_RST;
			tph_q  <= `TP_RST;
			bank_q <= `BANK_RST;
		end else if (BUS_I.wr) begin
			if (BUS_I.addr == `REG_TPL) tpl_q <= BUS_I.wdata;
			if (BUS_I.addr == `REG_TPH) tph_q <= BUS_I.wdata;
			if (BUS_I.addr == `REG_BANK) bank_q <= BUS_I.wdata[1:0];
		end
	end
	// table read sequencer; program memory answers one cycle after the strobe
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_q <= ST_IDLE;
			prd_q   <= 1'b0;
			paddr_q <= '0;
			dest_q  <= '0;
			busy_q  <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (take && CMD_I.op == OP_TBL_READ) begin
						state_q <= ST_FETCH;
						prd_q   <= 1'b1;
						paddr_q <= {tph_q, tpl_q};
						dest_q  <= m_addr;
						busy_q  <= 1'b1;
					end
				end
				ST_FETCH: begin
					state_q <= ST_LOAD;
					prd_q   <= 1'b0;
				end
				ST_LOAD: begin
					state_q <= ST_IDLE;
					busy_q  <= 1'b0;
				end
				default: begin
					state_q <= ST_IDLE;
					prd_q   <= 1'b0;
					busy_q  <= 1'b0;
				end
			endcase
		end
	end
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			thl_q <= `THL_RST;
		end else if (state_q == ST_LOAD) begin
			thl_q <= pm_hi;
		end
	end
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			done_q <= 1'b0;
		end else begin
			done_q <= (take && CMD_I.op != OP_TBL_READ && CMD_I.op != OP_NOP)
				|| state_q == ST_LOAD;
		end
	end
	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			rdata_q <= 8'h00;
		end else if (!BUS_I.rd) begin
			rdata_q <= 8'h00;
		end else if (bus_dm) begin
			rdata_q <= mem_bus;
		end else begin
			case (BUS_I.addr)
				`REG_ACC:    rdata_q <= acc_q;
				`REG_STATUS: rdata_q <= {3'h0, status_q};
				`REG_TPL:    rdata_q <= tpl_q;
				`REG_TPH:    rdata_q <= tph_q;
				`REG_THL:    rdata_q <= thl_q;
				`REG_BANK:   rdata_q <= {6'h00, bank_q};
				`REG_STATE:  rdata_q <= {7'h00, busy_q};
				default:     rdata_q <= 8'h00;
			endcase
		end
	end
	assign BUSY_O      = busy_q;
	assign DONE_O      = done_q;
	assign PM_RD_O     = prd_q;
	assign PM_ADDR_O   = paddr_q;
	assign BUS_RDATA_O = rdata_q;
	assign ACC_O       = acc_q;
	assign STATUS_O    = status_q;
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RST_N_I);
	a_tbl_sequence: assert property (
		take && CMD_I.op == OP_TBL_READ |=> PM_RD_O && PM_ADDR_O == {$past(tph_q), $past(tpl_q)}
			##1 !PM_RD_O && BUSY_O ##1 DONE_O && !BUSY_O)
		else $error("table read sequence wrong");
	a_tbl_load: assert property (
		state_q == ST_LOAD |-> mem_we && mem_wa == dest_q && mem_wd == PM_DATA_I[7:0]
			##1 thl_q == $past(pm_hi))
		else $error("table read data not stored");
	a_tbl_flags: assert property (
		state_q != ST_IDLE && !bus_st_wr |=> $stable(status_q))
		else $error("flags moved during table read");
	a_xor_acc: assert property (
		take && CMD_I.op == OP_XOR_ACC && !bus_st_wr |-> !(mem_we && !BUS_I.wr)
			##1 acc_q == ($past(acc_q) ^ $past(mem_m)) && status_q[`FLG_Z] == (acc_q == 8'h00)
			&& status_q[4:3] == $past(status_q[4:3]) && status_q[1:0] == $past(status_q[1:0]))
		else $error("xor to accumulator wrong");
	a_xor_mem: assert property (
		take && CMD_I.op == OP_XOR_MEM |-> mem_we && mem_wa == m_addr
			&& mem_wd == (acc_q ^ mem_m) ##1 status_q[`FLG_Z] == ($past(mem_wd) == 8'h00))
		else $error("xor to memory wrong");
	a_xor_imm: assert property (
		take && CMD_I.op == OP_XOR_IMM |=> acc_q == ($past(acc_q) ^ $past(CMD_I.imm)))
		else $error("xor immediate wrong");
	a_ext_address: assert property (
		take && is_ext |-> m_addr == CMD_I.addr)
		else $error("extended form used the bank");
	a_adc_acc: assert property (
		take && CMD_I.op == OP_ADC_ACC |=> acc_q ==
			8'($past(acc_q) + $past(mem_m) + {7'h00, $past(status_q[`FLG_C])}))
		else $error("add with carry wrong");
	a_add_flags: assert property (
		take && (CMD_I.op == OP_ADD_ACC || CMD_I.op == OP_ADD_MEM) |=>
			status_q[`FLG_C] == $past(sum9[8]) && status_q[`FLG_OV] == $past(ov)
			&& status_q[`FLG_Z] == ($past(sum9[7:0]) == 8'h00))
		else $error("add flags wrong");
	a_mem_arith: assert property (
		take && (CMD_I.op == OP_ADC_MEM || CMD_I.op == OP_ADD_MEM) |-> mem_we
			&& mem_wd == 8'(acc_q + mem_m + {7'h00, cin}))
		else $error("add to memory wrong");
	a_and_mem: assert property (
		take && CMD_I.op == OP_AND_MEM |-> mem_we && mem_wd == (acc_q & mem_m))
		else $error("and to memory wrong");
	a_clear_ops: assert property (
		take && CMD_I.op inside {OP_CLR_MEM, OP_CLR_BIT} && !bus_st_wr |-> mem_we
			&& (CMD_I.op != OP_CLR_MEM || mem_wd == `CLR_VALUE) ##1 $stable(status_q))
		else $error("clear wrong");
	c_table_read: cover property (state_q == ST_LOAD);
	c_carry_out:  cover property (take && CMD_I.op == OP_ADC_MEM && sum9[8]);
	c_back2back:  cover property (take ##1 take);
endmodule

// >>> inc/alu_defs.svh
`ifndef ALU_DEFS_SVH
`define ALU_DEFS_SVH

// widths
`define DM_ADDR_W   10
`define PM_ADDR_W   16
`define BUS_ADDR_W  12
`define STATUS_W    5

// register bus map, word per register
`define REG_ACC     12'h000
`define REG_STATUS  12'h001
`define REG_TPL     12'h002
`define REG_TPH     12'h003
`define REG_THL     12'h004
`define REG_BANK    12'h005
`define REG_STATE   12'h006
`define DM_WIN_BIT  11

// status field positions
`define FLG_C       0
`define FLG_AC      1
`define FLG_Z       2
`define FLG_OV      3
`define FLG_SC      4

// reset and fixed values
`define ACC_RST     8'h00
`define STATUS_RST  5'h00
`define TP_RST      8'h00
`define THL_RST     8'h00
`define BANK_RST    2'h0
`define CLR_VALUE   8'h00

`endif

// >>> inc/alu_pkg.sv
package alu_pkg;
`include "alu_defs.svh"

	typedef enum logic [3:0] {
		OP_NOP,
		OP_TBL_READ,
		OP_XOR_ACC,
		OP_XOR_MEM,
		OP_XOR_IMM,
		OP_ADC_ACC,
		OP_ADC_MEM,
		OP_ADD_ACC,
		OP_ADD_MEM,
		OP_AND_ACC,
		OP_AND_MEM,
		OP_CLR_MEM,
		OP_CLR_BIT
	} op_code_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_FETCH,
		ST_LOAD
	} state_t;

	typedef struct packed {
		op_code_t               op;
		logic [`DM_ADDR_W-1:0]  addr;
		logic [2:0]             bit_sel;
		logic [7:0]             imm;
	} cmd_t;

	typedef struct packed {
		logic [`BUS_ADDR_W-1:0] addr;
		logic [7:0]             wdata;
		logic                   wr;
		logic                   rd;
	} bus_req_t;

	typedef struct packed {
		logic                   we;
		logic [`DM_ADDR_W-1:0]  addr;
		logic [7:0]             data;
	} mem_wr_t;

endpackage

// >>> verilog/data_ram.sv
`timescale 1ns/100ps
`include "alu_defs.svh"
module data_ram import alu_pkg::*; #(
	parameter int AW = `DM_ADDR_W
) (
	// clock and reset
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	// write port
	input  wire mem_wr_t       wr_i,
	// two asynchronous read ports
	input  wire logic [AW-1:0] ra_addr_i,
	output logic [7:0]         ra_data_o,
	input  wire logic [AW-1:0] rb_addr_i,
	output logic [7:0]         rb_data_o
);
	logic [7:0] mem_q [(1<<AW)];

	// flops rather than a macro so both reads see the same cycle
	for (genvar i = 0; i < (1<<AW); i++) begin : g_byte
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				mem_q[i] <= 8'h00;
			end else if (wr_i.we && wr_i.addr == AW'(i)) begin
				mem_q[i] <= wr_i.data;
			end
		end
	end

	assign ra_data_o = mem_q[ra_addr_i];
	assign rb_data_o = mem_q[rb_addr_i];
endmodule

// >>> tb/alu_core_test.sv
`timescale 1ns/100ps
`include "alu_defs.svh"
module alu_core_test import alu_pkg::*;;
	logic                  clk;
	logic                  rst_n;
	logic                  cmd_valid;
	cmd_t                  cmd;
	logic                  busy;
	logic                  done;
	logic                  pm_rd;
	logic [`PM_ADDR_W-1:0] pm_addr;
	logic [15:0]           pm_data;
	bus_req_t              bus;
	logic [7:0]            bus_rdata;
	logic [7:0]            acc_o;
	logic [`STATUS_W-1:0]  status_o;
	// reference state kept beside the design
	logic [7:0]            mem_m [0:1023];
	logic [7:0]            acc_m;
	logic [7:0]            thl_m;
	logic [7:0]            tpl_m;
	logic [7:0]            tph_m;
	logic [4:0]            st_m;
	logic [1:0]            bank_m;
	int                    failures;
	int                    total_checks;
	int                    pm_hits;
	localparam logic [15:0] PM_WORD = 16'hA55A;

	alu_core alu_core_inst (
		.CLOCK_I     (clk),
		.RST_N_I     (rst_n),
		.CMD_VALID_I (cmd_valid),
		.CMD_I       (cmd),
		.BUSY_O      (busy),
		.DONE_O      (done),
		.PM_RD_O     (pm_rd),
		.PM_ADDR_O   (pm_addr),
		.PM_DATA_I   (pm_data),
		.BUS_I       (bus),
		.BUS_RDATA_O (bus_rdata),
		.ACC_O       (acc_o),
		.STATUS_O    (status_o)
	);

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// program memory answers only in the cycle after its strobe
	always @(posedge clk) pm_data <= (pm_rd === 1'b1) ? PM_WORD : 16'h0000;

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic summarize();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// model follows every write so later expectations stay exact
	task automatic bus_wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		bus <= '0;
		case (a)
			`REG_ACC: acc_m = d;
			`REG_STATUS: st_m = d[4:0];
			`REG_TPL: tpl_m = d;
			`REG_TPH: tph_m = d;
			`REG_BANK: bank_m = d[1:0];
			default: if (a[`DM_WIN_BIT]) mem_m[a[9:0]] = d;
		endcase
	endtask

	// data stands only in the cycle after the strobe
	task automatic bus_rd(input logic [11:0] a, input logic [7:0] exp, input string name);
		@(posedge clk);
		bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		bus <= '0;
		#1;
		check(name, exp, bus_rdata);
	endtask

	task automatic run(input op_code_t op, input logic [9:0] a, input logic [2:0] b,
			input logic [7:0] imm);
		logic [9:0] ea;
		logic [7:0] m;
		logic [7:0] r;
		logic [8:0] s;
		logic [4:0] h;
		logic       cin;
		int         i;
		ea = (op inside {OP_TBL_READ, OP_XOR_ACC, OP_XOR_MEM}) ? {bank_m, a[7:0]} : a;
		m = mem_m[ea];
		cin = (op inside {OP_ADC_ACC, OP_ADC_MEM}) ? st_m[`FLG_C] : 1'b0;
		s = acc_m + m + cin;
		h = acc_m[3:0] + m[3:0] + cin;
		case (op)
			OP_XOR_ACC, OP_XOR_MEM: r = acc_m ^ m;
			OP_XOR_IMM: r = acc_m ^ imm;
			OP_AND_ACC, OP_AND_MEM: r = acc_m & m;
			default: r = s[7:0];
		endcase
		if (op inside {OP_XOR_ACC, OP_XOR_MEM, OP_XOR_IMM, OP_AND_ACC, OP_AND_MEM}) begin
			st_m[`FLG_Z] = (r == 8'h00);
		end
		if (op inside {OP_ADC_ACC, OP_ADC_MEM, OP_ADD_ACC, OP_ADD_MEM}) begin
			st_m[`FLG_C] = s[8];
			st_m[`FLG_AC] = h[4];
			st_m[`FLG_Z] = (r == 8'h00);
			st_m[`FLG_OV] = (acc_m[7] == m[7]) && (r[7] != acc_m[7]);
			st_m[`FLG_SC] = st_m[`FLG_OV] ^ r[7];
		end
		if (op inside {OP_XOR_ACC, OP_XOR_IMM, OP_ADC_ACC, OP_ADD_ACC, OP_AND_ACC}) acc_m = r;
		if (op inside {OP_XOR_MEM, OP_ADC_MEM, OP_ADD_MEM, OP_AND_MEM}) mem_m[ea] = r;
		if (op == OP_CLR_MEM) mem_m[ea] = `CLR_VALUE;
		if (op == OP_CLR_BIT) mem_m[ea][b] = 1'b0;
		if (op == OP_TBL_READ) begin
			mem_m[ea] = PM_WORD[7:0];
			thl_m = PM_WORD[15:8];
		end
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: op, addr: a, bit_sel: b, imm: imm};
		@(posedge clk);
		cmd_valid <= 1'b0;
		i = 0;
		#1;
		while (done !== 1'b1 && i < 8) begin
			if (pm_rd === 1'b1) begin
				pm_hits++;
				check("pm_addr", {tph_m, tpl_m}, pm_addr);
				check("busy", 16'h0001, {15'h0000, busy});
			end
			@(posedge clk);
			#1;
			i++;
		end
		if (done !== 1'b1) begin
			failures++;
			$display("MISMATCH done expected 1 seen %b", done);
			summarize();
		end
		check("busy_end", 16'h0000, {15'h0000, busy});
		check("acc", acc_m, acc_o);
		check("status", st_m, status_o);
		bus_rd({2'b10, ea}, mem_m[ea], "mem");
	endtask

	initial begin
		rst_n = 1'b0;
		cmd_valid = 1'b0;
		cmd = '0;
		bus = '0;
		failures = 0;
		total_checks = 0;
		pm_hits = 0;
		acc_m = `ACC_RST;
		st_m = `STATUS_RST;
		thl_m = `THL_RST;
		tpl_m = `TP_RST;
		tph_m = `TP_RST;
		bank_m = `BANK_RST;
		for (int k = 0; k < 1024; k++) mem_m[k] = 8'h00;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		bus_rd(`REG_ACC, `ACC_RST, "acc_rst");
		bus_rd(`REG_STATUS, `STATUS_RST, "status_rst");
		bus_rd(`REG_THL, `THL_RST, "thl_rst");
		bus_rd(`REG_BANK, `BANK_RST, "bank_rst");
		bus_rd(12'h007, 8'h00, "unmapped");
		// same low byte in two sections exposes a banked extended access
		bus_wr(12'hA34, 8'h3C);
		bus_wr(12'hBF5, 8'h8F);
		bus_wr(12'h8F5, 8'h55);
		bus_wr(`REG_BANK, 8'h02);
		bus_wr(`REG_ACC, 8'hC3);
		bus_wr(`REG_STATUS, 8'h1F);
		run(OP_XOR_ACC, 10'h034, 3'd0, 8'h00);
		run(OP_XOR_MEM, 10'h034, 3'd0, 8'h00);
		run(OP_XOR_IMM, 10'h000, 3'd0, 8'hFF);
		bus_wr(`REG_BANK, 8'h00);
		bus_wr(`REG_ACC, 8'h71);
		bus_wr(`REG_STATUS, 8'h1F);
		run(OP_ADD_ACC, 10'h3F5, 3'd0, 8'h00);
		bus_wr(`REG_ACC, 8'h10);
		bus_wr(`REG_STATUS, 8'h01);
		run(OP_ADC_ACC, 10'h3F5, 3'd0, 8'h00);
		bus_wr(`REG_ACC, 8'h7F);
		bus_wr(`REG_STATUS, 8'h00);
		run(OP_ADD_MEM, 10'h3F5, 3'd0, 8'h00);
		bus_wr(`REG_ACC, 8'h72);
		bus_wr(`REG_STATUS, 8'h01);
		run(OP_ADC_MEM, 10'h3F5, 3'd0, 8'h00);
		bus_wr(`REG_ACC, 8'hF0);
		bus_wr(`REG_STATUS, 8'h1F);
		run(OP_AND_ACC, 10'h3F5, 3'd0, 8'h00);
		bus_wr(`REG_ACC, 8'h7E);
		bus_wr(`REG_STATUS, 8'h1B);
		run(OP_AND_MEM, 10'h3F5, 3'd0, 8'h00);
		bus_wr(12'hBF5, 8'hA7);
		bus_wr(`REG_STATUS, 8'h15);
		run(OP_CLR_MEM, 10'h3F5, 3'd0, 8'h00);
		bus_wr(12'hBF5, 8'hFF);
		for (int k = 0; k < 8; k++) run(OP_CLR_BIT, 10'h3F5, k[2:0], 8'h00);
		bus_rd(12'h8F5, 8'h55, "other_section");
		bus_wr(`REG_TPL, 8'h34);
		bus_wr(`REG_TPH, 8'h12);
		bus_wr(`REG_BANK, 8'h01);
		bus_wr(`REG_STATUS, 8'h0A);
		pm_hits = 0;
		run(OP_TBL_READ, 10'h010, 3'd0, 8'h00);
		check("pm_reads", 16'h0001, pm_hits[15:0]);
		bus_rd(`REG_THL, thl_m, "thl");
		// latch is read-only, a write must not change it
		bus_wr(`REG_THL, 8'h00);
		bus_rd(`REG_THL, thl_m, "thl_ro");
		bus_rd(`REG_STATE, 8'h00, "state_idle");
		// a command offered while the table read runs is ignored
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: OP_TBL_READ, addr: 10'h010, bit_sel: 3'd0, imm: 8'h00};
		@(posedge clk);
		cmd <= '{op: OP_XOR_IMM, addr: 10'h000, bit_sel: 3'd0, imm: 8'hFF};
		repeat (2) @(posedge clk);
		cmd_valid <= 1'b0;
		#1;
		check("done_tbl", 16'h0001, {15'h0000, done});
		check("acc_kept", acc_m, acc_o);
		check("status_kept", st_m, status_o);
		@(posedge clk);
		#1;
		check("done_pulse", 16'h0000, {15'h0000, done});
		check("acc_late", acc_m, acc_o);
		// two commands on consecutive edges are both taken
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= '{op: OP_XOR_IMM, addr: 10'h000, bit_sel: 3'd0, imm: 8'h0F};
		@(posedge clk);
		cmd <= '{op: OP_XOR_IMM, addr: 10'h000, bit_sel: 3'd0, imm: 8'hF0};
		@(posedge clk);
		cmd_valid <= 1'b0;
		#1;
		acc_m = acc_m ^ 8'hFF;
		st_m[`FLG_Z] = (acc_m == 8'h00);
		check("acc_b2b", acc_m, acc_o);
		check("status_b2b", st_m, status_o);
		summarize();
	end
endmodule
